/* rtl/iox_pkg.sv */
// constants shared by the serial i/o expander core
// assumes a single core clock of 10 MHz and the command map below
package iox_pkg;
  // core clock period and glitch filter width
  localparam int CLK_NS = 100;
  localparam int SPIKE_NS = 50;
  // spike filter length, rounded up, never below one cycle
  localparam int FILT_RAW = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_CYC = (FILT_RAW < 1) ? 1 : FILT_RAW;
  localparam logic [1:0] FILT_CNT = 2'(FILT_CYC);
  // release and output valid limits after an acknowledge
  localparam int VALID_US = 4;
  localparam int VALID_CYC = (VALID_US * 1000) / CLK_NS;

  // fixed upper five bits of the slave address, lsb is zero
  localparam logic [4:0] SLV_HI = 5'h16;
  localparam logic SLV_LSB = 1'b0;

  // command bytes
  localparam logic [7:0] CMD_IN_OD = 8'h00;
  localparam logic [7:0] CMD_IN_PP = 8'h01;
  localparam logic [7:0] CMD_OUT_OD = 8'h02;
  localparam logic [7:0] CMD_OUT_PP = 8'h03;
  localparam logic [7:0] CMD_DIR_OD = 8'h04;
  localparam logic [7:0] CMD_DIR_PP = 8'h05;
  localparam logic [7:0] CMD_MSK_OD = 8'h06;
  localparam logic [7:0] CMD_MSK_PP = 8'h07;
  localparam logic [7:0] CMD_LAST = 8'h07;

  // group index: open-drain group 0, push-pull group 1
  localparam int GRP_OD = 0;
  localparam int GRP_PP = 1;
  localparam int NIB = 4;

  // reset values
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] NIB_ONES = 4'hF;

  // serial engine states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_CMD = 4'h3,
    ST_CMD_ACK = 4'h4,
    ST_WR = 4'h5,
    ST_WR_ACK = 4'h6,
    ST_RD = 4'h7,
    ST_RD_ACK = 4'h8
  } iox_state_e;

  localparam logic [3:0] BIT_FULL = 4'h8;
endpackage

/* rtl/iox_expander.sv */
// serial-controlled eight port i/o expander, two 4-bit groups
// assumes scl/sda, pins and serial reset arrive unsynchronised
// Operation
// - 00h/01h read input level snapshots
// - 02h/03h output registers, reset by select pin
// - 04h-07h direction and mask, reset zero
// - only upper data nibble carries port values
// - select pin sets all power-up port states
// - input pin change pulls interrupt low
// - output pins and output register writes never interrupt
// - changes compared against last access level
// - group port read releases the interrupt
// - each group keeps its own change flags
// - mask pin while switching output to input
// - power-up clears detection and interrupt
// - internal reset restores every register default
// - serial reset aborts transfer to idle
// - serial reset keeps interrupt and flags
// - interrupt released within 4 us of ack
// - written output appears within 4 us
// - glitch filters reject pulses under 50 ns
// - select pin chooses one of two addresses
// - address 10110, select, 0, then direction
// - command byte follows address write
// - pins sampled and irq released at ack
// - direction one input, zero output
`timescale 1ns/1ps
module iox_expander (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic serial_rst_n_in,
  input wire logic addr_sel_in,
  input wire logic [3:0] push_pull_pins_in,
  output logic [3:0] push_pull_pins_out,
  output logic [3:0] push_pull_pins_oe_out,
  input wire logic [3:0] open_drain_pins_in,
  output logic [3:0] open_drain_pins_out,
  output logic [3:0] open_drain_pins_oe_out,
  output logic irq_n_out
);
  // line synchroniser slots
  localparam int LX_SDA = 0;
  localparam int LX_SCL = 1;
  localparam int LX_AD = 2;
  localparam int LX_RST = 3;

  // two-stage synchronisers, first stage read only by second
  logic [3:0] ln_meta_ff;
  logic [3:0] ln_sync_ff;
  logic [7:0] pin_meta_ff;
  logic [7:0] pin_sync_ff;
  // filtered bus lines and their previous values
  logic [1:0] flt_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  // serial engine
  iox_pkg::iox_state_e st_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] cmd_ff;
  logic [7:0] tx_ff;
  logic rw_ff;
  logic nack_ff;
  logic sda_drv_ff;
  // register file, index is the group
  logic [3:0] out_ff [2];
  logic [3:0] dir_ff [2];
  logic [3:0] mask_ff [2];
  logic [3:0] snap_ff [2];
  // transition detection per group
  logic [3:0] ref_ff [2];
  logic [3:0] prev_ff [2];
  logic [1:0] chg_ff;
  logic irq_n_ff;

  // decoded bus events
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic ser_abort;
  logic addr_hit;
  logic wr_go;
  logic rd_go;
  logic ad_lvl;
  logic [6:0] my_addr;
  // value of the selected register, ready for a read byte
  logic [7:0] rd_word;

  // read value of a register, low nibble reads zero
  function automatic logic [7:0] reg_read(input logic [7:0] cmd);
    logic [3:0] nib;
    nib = iox_pkg::NIB_ZERO;
    case (cmd)
      iox_pkg::CMD_IN_OD: nib = snap_ff[iox_pkg::GRP_OD];
      iox_pkg::CMD_IN_PP: nib = snap_ff[iox_pkg::GRP_PP];
      iox_pkg::CMD_OUT_OD: nib = out_ff[iox_pkg::GRP_OD];
      iox_pkg::CMD_OUT_PP: nib = out_ff[iox_pkg::GRP_PP];
      iox_pkg::CMD_DIR_OD: nib = dir_ff[iox_pkg::GRP_OD];
      iox_pkg::CMD_DIR_PP: nib = dir_ff[iox_pkg::GRP_PP];
      iox_pkg::CMD_MSK_OD: nib = mask_ff[iox_pkg::GRP_OD];
      iox_pkg::CMD_MSK_PP: nib = mask_ff[iox_pkg::GRP_PP];
      default: nib = iox_pkg::NIB_ZERO;
    endcase
    return {nib, iox_pkg::NIB_ZERO};
  endfunction

  // port read commands are the input and output groups
  function automatic logic is_port_cmd(input logic [7:0] cmd);
    return cmd <= iox_pkg::CMD_OUT_PP;
  endfunction

  // synchronise every outside level through two flops
  always_ff @(posedge core_clk_in) begin
    ln_meta_ff <= {serial_rst_n_in, addr_sel_in, scl_in, sda_in};
    ln_sync_ff <= ln_meta_ff;
    pin_meta_ff <= {push_pull_pins_in, open_drain_pins_in};
    pin_sync_ff <= pin_meta_ff;
  end

  // spike filter on scl and sda: value taken once stable
  generate
    for (genvar k = 0; k < 2; k++) begin : g_filt
      logic prv_ff;
      logic [1:0] cnt_ff;
      logic lvl_ff;
      always_ff @(posedge core_clk_in) begin
        prv_ff <= ln_sync_ff[k];
        if (srst_in) begin
          cnt_ff <= 2'h0;
          lvl_ff <= 1'b1;
        end else if (ln_sync_ff[k] != prv_ff) begin
          cnt_ff <= 2'h0;
        end else if (cnt_ff < iox_pkg::FILT_CNT) begin
          cnt_ff <= cnt_ff + 2'h1;
        end else begin
          lvl_ff <= prv_ff;
        end
      end
      // filtered level, each bit has a single driver
      assign flt_ff[k] = lvl_ff;
    end
  endgenerate

  // previous filtered levels for edge detection
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= flt_ff[LX_SCL];
      sda_d_ff <= flt_ff[LX_SDA];
    end
  end

  assign ad_lvl = ln_sync_ff[LX_AD];
  assign my_addr = {iox_pkg::SLV_HI, ad_lvl, iox_pkg::SLV_LSB};
  assign scl_rise = flt_ff[LX_SCL] & ~scl_d_ff;
  assign scl_fall = ~flt_ff[LX_SCL] & scl_d_ff;
  // start and stop: sda moves while scl stays high
  assign bus_start = scl_d_ff & flt_ff[LX_SCL] & sda_d_ff
                     & ~flt_ff[LX_SDA];
  assign bus_stop = scl_d_ff & flt_ff[LX_SCL] & ~sda_d_ff
                    & flt_ff[LX_SDA];
  assign ser_abort = ~ln_sync_ff[LX_RST];
  // register read value, sensitive to every register it selects
  always_comb begin
    rd_word = reg_read(cmd_ff);
  end
  assign addr_hit = (shift_ff[7:1] == my_addr);
  // write commits as the data acknowledge ends
  assign wr_go = scl_fall & ~ser_abort & ~bus_start & ~bus_stop
                 & (st_ff == iox_pkg::ST_WR_ACK);
  // read address acknowledge begins: sample pins, clear flags
  assign rd_go = scl_fall & ~ser_abort & ~bus_start & ~bus_stop
                 & (st_ff == iox_pkg::ST_ADDR)
                 & (bit_cnt_ff == iox_pkg::BIT_FULL)
                 & addr_hit & shift_ff[0];

  // serial engine: shift on scl rise, act on scl fall
  always_ff @(posedge core_clk_in) begin
    if (srst_in || ser_abort) begin
      st_ff <= iox_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      sda_drv_ff <= 1'b0;
      nack_ff <= 1'b0;
      if (srst_in) begin
        shift_ff <= 8'h00;
        cmd_ff <= 8'h00;
        tx_ff <= 8'h00;
        rw_ff <= 1'b0;
      end
    end else if (bus_start) begin
      // start or repeated start: expect an address
      st_ff <= iox_pkg::ST_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_drv_ff <= 1'b0;
    end else if (bus_stop) begin
      st_ff <= iox_pkg::ST_IDLE;
      sda_drv_ff <= 1'b0;
    end else if (scl_rise) begin
      case (st_ff)
        iox_pkg::ST_ADDR, iox_pkg::ST_CMD, iox_pkg::ST_WR: begin
          shift_ff <= {shift_ff[6:0], flt_ff[LX_SDA]};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
        // master answer to a read byte
        iox_pkg::ST_RD_ACK: nack_ff <= flt_ff[LX_SDA];
        default: nack_ff <= nack_ff;
      endcase
    end else if (scl_fall) begin
      case (st_ff)
        iox_pkg::ST_ADDR: begin
          if (bit_cnt_ff == iox_pkg::BIT_FULL) begin
            bit_cnt_ff <= 4'h0;
            if (addr_hit) begin
              st_ff <= iox_pkg::ST_ADDR_ACK;
              rw_ff <= shift_ff[0];
              sda_drv_ff <= 1'b1;
            end else begin
              st_ff <= iox_pkg::ST_IDLE;
            end
          end
        end
        iox_pkg::ST_ADDR_ACK: begin
          if (rw_ff) begin
            // first data bit goes out as the ack ends
            tx_ff <= rd_word;
            sda_drv_ff <= ~rd_word[7];
            bit_cnt_ff <= 4'h1;
            st_ff <= iox_pkg::ST_RD;
          end else begin
            sda_drv_ff <= 1'b0;
            st_ff <= iox_pkg::ST_CMD;
          end
        end
        iox_pkg::ST_CMD: begin
          if (bit_cnt_ff == iox_pkg::BIT_FULL) begin
            cmd_ff <= shift_ff;
            bit_cnt_ff <= 4'h0;
            sda_drv_ff <= 1'b1;
            st_ff <= iox_pkg::ST_CMD_ACK;
          end
        end
        iox_pkg::ST_CMD_ACK, iox_pkg::ST_WR_ACK: begin
          sda_drv_ff <= 1'b0;
          st_ff <= iox_pkg::ST_WR;
        end
        iox_pkg::ST_WR: begin
          if (bit_cnt_ff == iox_pkg::BIT_FULL) begin
            bit_cnt_ff <= 4'h0;
            sda_drv_ff <= 1'b1;
            st_ff <= iox_pkg::ST_WR_ACK;
          end
        end
        iox_pkg::ST_RD: begin
          if (bit_cnt_ff == iox_pkg::BIT_FULL) begin
            sda_drv_ff <= 1'b0;
            st_ff <= iox_pkg::ST_RD_ACK;
          end else begin
            sda_drv_ff <= ~tx_ff[3'(4'h7 - bit_cnt_ff)];
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        iox_pkg::ST_RD_ACK: begin
          if (nack_ff) begin
            st_ff <= iox_pkg::ST_IDLE;
          end else begin
            // further bytes repeat the same register
            tx_ff <= rd_word;
            sda_drv_ff <= ~rd_word[7];
            bit_cnt_ff <= 4'h1;
            st_ff <= iox_pkg::ST_RD;
          end
        end
        default: st_ff <= iox_pkg::ST_IDLE;
      endcase
    end
  end

  // register writes, one group at a time
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      for (int g = 0; g < 2; g++) begin
        out_ff[g] <= ad_lvl ? iox_pkg::NIB_ONES : iox_pkg::NIB_ZERO;
        dir_ff[g] <= iox_pkg::NIB_ZERO;
        mask_ff[g] <= iox_pkg::NIB_ZERO;
      end
    end else if (wr_go) begin
      // only the upper nibble is stored
      case (cmd_ff)
        iox_pkg::CMD_OUT_OD: out_ff[iox_pkg::GRP_OD] <= shift_ff[7:4];
        iox_pkg::CMD_OUT_PP: out_ff[iox_pkg::GRP_PP] <= shift_ff[7:4];
        iox_pkg::CMD_DIR_OD: dir_ff[iox_pkg::GRP_OD] <= shift_ff[7:4];
        iox_pkg::CMD_DIR_PP: dir_ff[iox_pkg::GRP_PP] <= shift_ff[7:4];
        iox_pkg::CMD_MSK_OD: mask_ff[iox_pkg::GRP_OD] <= shift_ff[7:4];
        iox_pkg::CMD_MSK_PP: mask_ff[iox_pkg::GRP_PP] <= shift_ff[7:4];
        default: out_ff[iox_pkg::GRP_OD] <= out_ff[iox_pkg::GRP_OD];
      endcase
    end
  end

  // input snapshot taken at the read address acknowledge
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      snap_ff[iox_pkg::GRP_OD] <= iox_pkg::NIB_ZERO;
      snap_ff[iox_pkg::GRP_PP] <= iox_pkg::NIB_ZERO;
    end else if (rd_go) begin
      snap_ff[iox_pkg::GRP_OD] <= pin_sync_ff[3:0];
      snap_ff[iox_pkg::GRP_PP] <= pin_sync_ff[7:4];
    end
  end

  // transition detection, one flag per group
  generate
    for (genvar g = 0; g < 2; g++) begin : g_chg
      logic [3:0] pins;
      logic [3:0] watch;
      logic clr;
      logic [3:0] ref_q_ff;
      logic [3:0] prev_q_ff;
      logic chg_q_ff;
      assign pins = pin_sync_ff[g*iox_pkg::NIB +: iox_pkg::NIB];
      // output pins and masked pins never count
      // mask bit hides a switching pin
      assign watch = dir_ff[g] & ~mask_ff[g];
      // only a read of this group clears it
      assign clr = rd_go & is_port_cmd(cmd_ff) & (cmd_ff[0] == 1'(g));
      // serial reset never touches the flags
      always_ff @(posedge core_clk_in) begin
        prev_q_ff <= pins;
        if (srst_in) begin
          ref_q_ff <= pins;
          chg_q_ff <= 1'b0;
        end else if (clr) begin
          // read releases, a same-cycle edge still sets
          ref_q_ff <= pins;
          chg_q_ff <= |((pins ^ prev_q_ff) & watch);
        end else begin
          // compare against level at last access
          // an input change raises the flag
          chg_q_ff <= chg_q_ff | (|((pins ^ ref_q_ff) & watch));
        end
      end
      // group state seen by the rest of the block
      assign prev_ff[g] = prev_q_ff;
      assign ref_ff[g] = ref_q_ff;
      assign chg_ff[g] = chg_q_ff;
    end
  endgenerate

  // latched interrupt, low while any group flag stands
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      irq_n_ff <= 1'b1;
    end else begin
      // released two cycles after the clearing ack, one after the flag clears
      irq_n_ff <= ~(|chg_ff);
    end
  end

  assign irq_n_out = irq_n_ff;
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_drv_ff;
  // pins follow the output register directly
  // nibble bit 3 drives pin 3
  assign push_pull_pins_out = out_ff[iox_pkg::GRP_PP];
  assign push_pull_pins_oe_out = ~dir_ff[iox_pkg::GRP_PP];
  // open-drain pins only pull low, a one releases
  assign open_drain_pins_out = iox_pkg::NIB_ZERO;
  assign open_drain_pins_oe_out = ~dir_ff[iox_pkg::GRP_OD]
                                  & ~out_ff[iox_pkg::GRP_OD];

  // checks kept beside the logic they guard
  a_rst_defaults: assert property (@(posedge core_clk_in)
    srst_in |=> dir_ff[0] == 4'h0 && mask_ff[1] == 4'h0 && irq_n_out)
    else $error("defaults not restored by reset");
  a_pwr_outputs: assert property (@(posedge core_clk_in)
    srst_in && ad_lvl |=> push_pull_pins_out == 4'hF
    && open_drain_pins_oe_out == 4'h0)
    else $error("select-high power state wrong");
  a_ser_abort: assert property (@(posedge core_clk_in)
    disable iff (srst_in) ser_abort |=> st_ff == iox_pkg::ST_IDLE
    && !sda_oe_out)
    else $error("serial reset did not idle the bus");
  a_keep_flags: assert property (@(posedge core_clk_in)
    disable iff (srst_in) ser_abort && chg_ff[0] |=> chg_ff[0])
    else $error("serial reset dropped a change flag");
  a_foreign_addr: assert property (@(posedge core_clk_in)
    disable iff (srst_in || ser_abort) st_ff == iox_pkg::ST_ADDR
    && scl_fall && !bus_start && !bus_stop
    && bit_cnt_ff == iox_pkg::BIT_FULL && !addr_hit
    |=> st_ff == iox_pkg::ST_IDLE && !sda_oe_out)
    else $error("foreign address acknowledged");
  a_pp_write: assert property (@(posedge core_clk_in)
    disable iff (srst_in) wr_go && cmd_ff == iox_pkg::CMD_OUT_PP
    |=> push_pull_pins_out == $past(shift_ff[7:4]))
    else $error("push-pull write not on pins");
  a_irq_release: assert property (@(posedge core_clk_in)
    disable iff (srst_in) g_chg[0].clr && !g_chg[1].clr && !chg_ff[1]
    && pin_sync_ff[3:0] == prev_ff[0] ##1 !chg_ff[1]
    |=> irq_n_out)
    else $error("group read did not release interrupt");
  a_out_quiet: assert property (@(posedge core_clk_in)
    disable iff (srst_in) dir_ff[1] == 4'h0 && !chg_ff[1]
    |=> !chg_ff[1])
    else $error("output pin raised a change");
  a_group_apart: assert property (@(posedge core_clk_in)
    disable iff (srst_in) g_chg[1].clr && chg_ff[0]
    && !g_chg[0].clr |=> chg_ff[0])
    else $error("other group read cleared flag");
  a_in_change: assert property (@(posedge core_clk_in)
    disable iff (srst_in) !g_chg[0].clr
    && |((pin_sync_ff[3:0] ^ ref_ff[0]) & dir_ff[0] & ~mask_ff[0])
    |=> chg_ff[0] ##1 !irq_n_out)
    else $error("input change not flagged");
endmodule

/* tb/iox_bus_mst.sv */
// serial bus master model: drives the clock and pulls the data line
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module iox_bus_mst (
  output logic scl_out,
  output logic sda_pull_out,
  input wire logic sda_in,
  input wire logic core_clk_in
);
  // fifth of a bit; low phase is three fifths, high phase two
  localparam int Q = 400;
  // idle bus: both lines released high
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // move off the core clock edges so the two never race
  task automatic align();
    @(negedge core_clk_in);
    #13;
  endtask
  // start or repeated start, clock left low
  task automatic start();
    align();
    sda_pull_out <= 1'b0;
    #(Q) scl_out <= 1'b1;
    #(Q) sda_pull_out <= 1'b1;
    #(Q) scl_out <= 1'b0;
  endtask
  // one bit: data set while low, sampled in the middle of the high phase
  task automatic bit_io(input logic b, output logic s);
    #(Q) sda_pull_out <= ~b;
    #(2*Q) scl_out <= 1'b1;
    #(Q) s = sda_in;
    #(Q) scl_out <= 1'b0;
  endtask
  // byte sent msb first, then the ninth clock
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // byte received; the last one is not acknowledged
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
  // stop, then bus free time
  task automatic stop();
    #(Q) sda_pull_out <= 1'b1;
    #(2*Q) scl_out <= 1'b1;
    #(2*Q) sda_pull_out <= 1'b0;
    #(4*Q);
  endtask
  // 40 ns spike on the clock while it is low
  task automatic glitch();
    #(Q) scl_out <= 1'b1;
    #40 scl_out <= 1'b0;
  endtask
endmodule

/* tb/iox_expander_tb_top.sv */
// self-checking bench for the serial i/o expander
// assumes the master model in iox_bus_mst and pull-ups resolved here
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) begin \
      miscompares++; \
      $display("[ERR] %s exp %h got %h", nm, ex, got); \
    end \
  end
module iox_expander_tb_top;
  // inputs and far-side pin levels
  logic clk, srst, ser_rst_n, ad;
  logic [3:0] pp_ext, od_ext;
  // bus wires and dut outputs
  logic scl, m_pull, sda, sda_o, sda_oe, irq_n;
  logic [3:0] pp_out, pp_oe, od_out, od_oe, pp_pin, od_pin;
  int compares = 0;
  int miscompares = 0;
  int cyc = 0;
  // wired data line and pins: whoever enables drives, else outside
  assign sda = ~m_pull & (sda_oe ? sda_o : 1'b1);
  assign pp_pin = (pp_oe & pp_out) | (~pp_oe & pp_ext);
  assign od_pin = (od_oe & od_out) | (~od_oe & od_ext);
  iox_expander u_dut (.core_clk_in(clk), .srst_in(srst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .serial_rst_n_in(ser_rst_n), .addr_sel_in(ad),
    .push_pull_pins_in(pp_pin), .push_pull_pins_out(pp_out),
    .push_pull_pins_oe_out(pp_oe), .open_drain_pins_in(od_pin),
    .open_drain_pins_out(od_out), .open_drain_pins_oe_out(od_oe),
    .irq_n_out(irq_n));
  iox_bus_mst u_mst (.scl_out(scl), .sda_pull_out(m_pull),
    .sda_in(sda), .core_clk_in(clk));
  // 10 MHz core clock
  always #50 clk = ~clk;
  // hang guard, nearly three times the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // reset held 6 cycles with the select level given
  task automatic do_reset(input logic a);
    @(posedge clk);
    ad <= a;
    srst <= 1'b1;
    waitc(6);
    srst <= 1'b0;
    waitc(4);
  endtask
  task automatic reg_wr(input logic [7:0] c, input logic [7:0] d);
    logic k0, k1, k2;
    u_mst.start();
    u_mst.put({5'h16, ad, 2'b00}, k0);
    u_mst.put(c, k1);
    u_mst.put(d, k2);
    u_mst.stop();
    `CHK("write acks", 3'b111, {k0, k1, k2})
  endtask
  task automatic reg_rd(input logic [7:0] c, output logic [7:0] d);
    logic k0, k1, k2;
    u_mst.start();
    u_mst.put({5'h16, ad, 2'b00}, k0);
    u_mst.put(c, k1);
    u_mst.start();
    u_mst.put({5'h16, ad, 2'b01}, k2);
    u_mst.get(1'b1, d);
    u_mst.stop();
    `CHK("read acks", 3'b111, {k0, k1, k2})
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic [7:0] ex);
    logic [7:0] d;
    reg_rd(c, d);
    `CHK("read data", ex, d)
  endtask
  // power-up pins and register defaults
  task automatic t_defaults(input logic a);
    `CHK("pp out", a ? 4'hF : 4'h0, pp_out)
    `CHK("od oe", a ? 4'h0 : 4'hF, od_oe)
    `CHK("pp oe", 4'hF, pp_oe)
    `CHK("irq idle", 1'b1, irq_n)
    for (int c = 2; c < 8; c++) begin
      rd_chk(8'(c), (c < 4 && a) ? 8'hF0 : 8'h00);
    end
    $display("t_defaults done");
  endtask
  // output writes and output pin activity
  task automatic t_outputs();
    reg_wr(8'h03, 8'hA5);
    `CHK("pp pins", 4'hA, pp_out)
    rd_chk(8'h03, 8'hA0);
    reg_wr(8'h02, 8'h50);
    `CHK("od pins", 4'hA, od_oe)
    @(posedge clk);
    pp_ext <= 4'h3;
    od_ext <= 4'h0;
    waitc(50);
    `CHK("irq quiet", 1'b1, irq_n)
    $display("t_outputs done");
  endtask
  // turn group g into inputs behind the mask, then unmask
  task automatic t_arm(input logic [7:0] g);
    logic [7:0] d;
    reg_wr(8'h06 + g, 8'hF0);
    reg_wr(8'h04 + g, 8'hF0);
    @(posedge clk);
    if (g[0]) begin
      pp_ext <= ~pp_ext;
    end else begin
      od_ext <= ~od_ext;
    end
    waitc(50);
    `CHK("irq masked", 1'b1, irq_n)
    reg_rd(g, d);
    reg_wr(8'h06 + g, 8'h00);
    waitc(50);
    `CHK("irq armed", 1'b1, irq_n)
    `CHK("oe off", 4'h0, g[0] ? pp_oe : od_oe)
    $display("t_arm done");
  endtask
  // change on one group, read the other, then its own
  task automatic t_change();
    @(posedge clk);
    od_ext <= od_ext ^ 4'h8;
    waitc(40);
    `CHK("irq set", 1'b0, irq_n)
    rd_chk(8'h01, {pp_ext, 4'h0});
    `CHK("irq kept", 1'b0, irq_n)
    rd_chk(8'h00, {od_ext, 4'h0});
    `CHK("irq clear", 1'b1, irq_n)
    $display("t_change done");
  endtask
  // a short pulse that returns to its level stays latched
  task automatic t_transient();
    @(posedge clk);
    pp_ext <= pp_ext ^ 4'h1;
    waitc(5);
    pp_ext <= pp_ext ^ 4'h1;
    waitc(40);
    `CHK("irq latched", 1'b0, irq_n)
    rd_chk(8'h01, {pp_ext, 4'h0});
    `CHK("irq clear", 1'b1, irq_n)
    $display("t_transient done");
  endtask
  // clock spike inside a write must not add a bit
  task automatic t_glitch();
    logic k0, k1, k2;
    u_mst.start();
    u_mst.put({5'h16, ad, 2'b00}, k0);
    u_mst.glitch();
    u_mst.put(8'h03, k1);
    u_mst.put(8'h50, k2);
    u_mst.stop();
    `CHK("spike acks", 3'b111, {k0, k1, k2})
    `CHK("pp pins", 4'h5, pp_out)
    $display("t_glitch done");
  endtask
  // serial reset in mid-write with a change pending
  task automatic t_ser_rst();
    logic k0, k1, k2;
    @(posedge clk);
    od_ext <= od_ext ^ 4'h1;
    waitc(40);
    u_mst.start();
    u_mst.put({5'h16, ad, 2'b00}, k0);
    @(posedge clk);
    ser_rst_n <= 1'b0;
    // low 600 ns, then 1.1 us before the bus moves
    waitc(6);
    ser_rst_n <= 1'b1;
    waitc(11);
    u_mst.align();
    u_mst.put(8'h03, k1);
    u_mst.put(8'hF0, k2);
    u_mst.stop();
    `CHK("aborted acks", 3'b100, {k0, k1, k2})
    `CHK("pp pins", 4'h5, pp_out)
    `CHK("irq kept", 1'b0, irq_n)
    rd_chk(8'h00, {od_ext, 4'h0});
    `CHK("irq clear", 1'b1, irq_n)
    $display("t_ser_rst done");
  endtask
  // foreign addresses get no ack, unmapped command reads zero
  task automatic t_addr();
    logic k;
    for (int i = 0; i < 2; i++) begin
      u_mst.start();
      u_mst.put(i ? 8'hB8 : {5'h16, ~ad, 2'b00}, k);
      u_mst.stop();
      `CHK("foreign ack", 1'b0, k)
    end
    rd_chk(8'h08, 8'h00);
    $display("t_addr done");
  endtask
  // main sequence
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    ad = 1'b0;
    ser_rst_n = 1'b1;
    pp_ext = 4'h0;
    od_ext = 4'hF;
    do_reset(1'b0);
    t_defaults(1'b0);
    t_outputs();
    t_arm(8'h00);
    t_arm(8'h01);
    t_change();
    t_transient();
    t_glitch();
    t_ser_rst();
    do_reset(1'b1);
    t_defaults(1'b1);
    t_addr();
    tally_and_finish();
  end
endmodule
